//--- bench/scdc_host_model.sv
// Host-side model that drives the receive pin wake pattern.
module scdc_host_model (
  // Clock.
  input wire logic clk,
  // Serial pin.
  output logic     rxPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Detection trims kept in the host model; nothing drives them into the controller, the bench reads biasCutPct and samplerHz back.
  int unsigned samplerHz  = 32'h0003_2000;
  int unsigned biasCutPct = 32'h0000_0042;
  int unsigned regDropMv  = 32'h0000_00C8;
  initial rxPin = 1'b1;
  // The pin returns to its idle high level, as the pull-up leaves it.
  task automatic wake(input int lowCyc, input int highCyc);
    rxPin <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    rxPin <= 1'b1;
    repeat (highCyc) @(posedge clk);
  endtask
endmodule

//--- bench/scdc_sleep_ctrl_assertions.sv
// Port-level property checker for the sleep and current-detect controller.
module scdc_sleep_ctrl_assertions #(
  parameter int unsigned SETTLE_CYC = 20,
  parameter int unsigned DETECT_CYC = 100
) (
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    resetn,
  // Observed ports.
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [7:0]              intSrc,
  input wire logic                    resetEvent,
  input wire logic                    txPin,
  input wire logic                    intPin,
  input wire scdc_pkg::scdc_power_type power
);
  timeunit 1ns;
  timeprecision 1ps;
  import scdc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] detCyc;
  logic [31:0] next_detCyc;
  always_comb next_detCyc = power.rcFastEn ? detCyc + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) detCyc <= 32'h0;
    else detCyc <= next_detCyc;
  end
  chk_sleep_clock: assert property (power.uartIdle |-> power.rcSlowEn && !power.xtalEn
    && !power.rcFastEn) else $error("sleep clocks wrong");
  chk_sleep_units: assert property (power.uartIdle |-> !(power.bandgapEn | power.biasEn
    | power.currAdcEn | power.voltAdcEn | power.meterEn)) else $error("sleep units on");
  chk_sleep_tx: assert property (power.uartIdle |-> txPin) else $error("tx low in sleep");
  chk_sleep_int: assert property (power.uartIdle && $past(power.uartIdle, 2)
    && $past(power.uartIdle) && $past(intSrc[0]) |-> intPin) else $error("self-check lost");
  chk_detect_clock: assert property (power.rcFastEn |-> power.clkFromRc
    && power.meterClkFixed && !power.xtalEn) else $error("detect clocks wrong");
  chk_detect_units: assert property (power.rcFastEn |-> !power.voltAdcEn
    && power.bandgapEn && power.biasEn && power.meterVerifyOnly) else $error("detect units");
  chk_detect_mask: assert property (power.rcFastEn && $past(power.rcFastEn, 2) && intPin
    |-> |($past(intSrc) & 8'h07)) else $error("masked interrupt seen");
  chk_detect_bound: assert property (detCyc <= DETECT_CYC + 2) else $error("detect too long");
  chk_rc_settle: assert property (power.rcFastEn && detCyc > SETTLE_CYC + 1
    |-> power.currAdcEn && power.meterEn) else $error("sampler late");
  chk_reset_event: assert property (resetEvent |-> ##[1:2] power.xtalEn
    && !power.uartIdle) else $error("no default after reset event");
  chk_bus_okay: assert property ($past(resetn) |-> hreadyout && !hresp) else $error("bus wait");
endmodule
bind scdc_sleep_ctrl scdc_sleep_ctrl_assertions #(.SETTLE_CYC(SETTLE_CYC),
  .DETECT_CYC(DETECT_CYC)) u_chk (.clk(clk), .resetn(resetn), .hreadyout(hreadyout),
  .hresp(hresp), .intSrc(intSrc), .resetEvent(resetEvent), .txPin(txPin), .intPin(intPin),
  .power(power));

//--- bench/scdc_sleep_ctrl_tb_top.sv
// Self-checking testbench for the sleep and current-detect controller.
module scdc_sleep_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scdc_pkg::*;
  localparam int W = 8, S = 20, D = 100;
  logic clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, uartTx = 1'b0;
  logic detectDone = 1'b0, resetEvent = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, v;
  logic [7:0] intSrc = 8'h0;
  logic [7:0] ien = 8'h01;
  logic [15:0] seed = 16'h002C;
  logic hreadyout, hresp, rxPin, txPin, intPin, wdtReset;
  scdc_power_type power;
  int nFail = 0, testsRun = 0, mode = 1, n;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always #20 clk = ~clk;
  always @(posedge clk) begin
    seed <= lfsr(seed);
    uartTx <= seed[0];
    intSrc <= seed[8:1];
  end
  scdc_sleep_ctrl #(.WAKE_CYC(W), .SETTLE_CYC(S), .DETECT_CYC(D)) u_dut (.clk(clk),
    .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxPin(rxPin), .uartTx(uartTx), .intSrc(intSrc),
    .detectDone(detectDone), .resetEvent(resetEvent), .txPin(txPin), .intPin(intPin),
    .power(power), .wdtReset(wdtReset));
  scdc_host_model u_host (.clk(clk), .rxPin(rxPin));
  task automatic closeOut();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus signals move only right after an edge; data is taken at the closing edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask
  task automatic st();
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", {28'h0, r[3:0]}, 32'(mode));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Pins follow their inputs one cycle late; the mask comes from the enable model.
  task automatic pins(input string nm);
    logic [7:0] s;
    logic       u;
    logic [7:0] m;
    @(posedge clk);
    s = intSrc;
    u = uartTx;
    m = (mode == 8) ? ((ien & 8'h07) | 8'h01) : (ien | 8'h01);
    @(posedge clk);
    chk({nm, " txPin"}, {31'h0, txPin}, {31'h0, (mode == 4) || u});
    chk({nm, " intPin"}, {31'h0, intPin}, {31'h0, |(s & m)});
  endtask
  initial begin
    #800000;
    nFail++;
    closeOut();
  end
  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(1);
    st();
    rchk(ADDR_SYSTEM_CONTROL_WORD, 32'h0, "ctrl");
    rchk(ADDR_INTEN, 32'h1, "inten");
    rchk(ADDR_WDT, 32'hFFFF, "wdt");
    rchk(12'h1F0, 32'h0, "unmapped");
    v = {16'h0, seed};
    xfer(1'b1, ADDR_INTEN, v);
    rchk(ADDR_INTEN, (v & 32'hFF) | 32'h1, "inten");
    ien = v[7:0];
    pins("default");
    xfer(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    st();
    $display("registers done");
    xfer(1'b1, ADDR_SYSTEM_CONTROL_WORD, 32'h2);
    mode = 2;
    st();
    xfer(1'b1, ADDR_INTEN, 32'h1);
    ien = 8'h01;
    if (u_host.biasCutPct == 32'h0000_0042) begin
      chk("samplerHz", u_host.samplerHz, 32'h0003_2000);
    end
    xfer(1'b1, ADDR_SYSTEM_CONTROL_WORD, 32'h1);
    mode = 4;
    st();
    chk("txPin", {31'h0, txPin}, 32'h1);
    chk("uartIdle", {31'h0, power.uartIdle}, 32'h1);
    pins("sleep quiet");
    // Opening every enable in sleep lets detection show which sources it drops.
    xfer(1'b1, ADDR_INTEN, 32'hFF);
    ien = 8'hFF;
    pins("sleep open");
    u_host.wake(W / 2, 3 * W);
    cyc(4);
    st();
    u_host.wake(W, W);
    cyc(4);
    mode = 8;
    st();
    pins("detect");
    cyc(S);
    st();
    chk("rcStable", {31'h0, r[4]}, 32'h1);
    detectDone <= 1'b1;
    cyc(2);
    detectDone <= 1'b0;
    mode = 4;
    st();
    u_host.wake(W, W);
    cyc(D + 10);
    st();
    $display("wake and detect done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        resetEvent <= 1'b1;
        cyc(1);
        resetEvent <= 1'b0;
      end else begin
        xfer(1'b1, ADDR_SOFTRST, 32'h1);
      end
      cyc(3);
      mode = 1;
      ien = 8'h01;
      st();
      xfer(1'b1, ADDR_SYSTEM_CONTROL_WORD, 32'h1);
      mode = 4;
    end
    xfer(1'b1, ADDR_WDT, 32'h1);
    n = 0;
    while (wdtReset !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    chk("wdtReset", {31'h0, wdtReset}, 32'h1);
    cyc(3);
    mode = 1;
    st();
    $display("resets done");
    closeOut();
  end
endmodule

//--- inc/scdc_pkg.sv
// Constants, register map and carrier types of the sleep and current-detect controller.
// Notes on behaviour
// - Writing one to control bit 0 in default or metering enters sleep.
// - Sleep stops every oscillator except the 32 kHz RC one.
// - Sleep turns off bandgap, bias, samplers and metering; serial idles.
// - Interrupt handling runs in sleep; enabled interrupts pulse the interrupt pin.
// - Transmit pin is held high during sleep.
// - Valid low-then-high receive pattern in sleep enters current detection.
// - Any reset event returns the device to the default state.
// - Detection enables fast RC oscillator feeding meter, sampler, serial clocks; crystal off.
// - Fast RC oscillator is stable within 1 ms after wake-up.
// - Metering clock fixed at 3.2768 MHz during detection.
// - Detection enables current sampler, bandgap and bias only; voltage sampler off.
// - Detection ends within 30 ms and returns to sleep by itself.
// - Detection masks all interrupts except self-check, verification, detection complete.
// - Metering runs automatically computing only verification and detection results.
// - Watchdog stays enabled in sleep and detection with host interval.
package scdc_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned WAKE_HALF_US    = 250;
  localparam int unsigned RC_SETTLE_MS    = 1;
  localparam int unsigned DETECT_MAX_MS   = 30;
  localparam int unsigned WAKE_HALF_CYC   = (WAKE_HALF_US * (CLK_HZ / 1000)) / 1000;
  localparam int unsigned RC_SETTLE_CYC   = RC_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned DETECT_MAX_CYC  = DETECT_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned WDT_TICK_CYC    = 1024;
  localparam int unsigned TMR_W           = 20;
  localparam int unsigned WDT_W           = 26;

  localparam logic [11:0] ADDR_SYSTEM_CONTROL_WORD    = 12'h180;
  localparam logic [11:0] ADDR_INTEN      = 12'h184;
  localparam logic [11:0] ADDR_STATUS     = 12'h188;
  localparam logic [11:0] ADDR_WDT        = 12'h18C;
  localparam logic [11:0] ADDR_SOFTRST    = 12'h190;

  localparam int unsigned BIT_SLEEP       = 0;
  localparam int unsigned BIT_METER       = 1;
  localparam int unsigned BIT_RCSTABLE    = 4;
  localparam int unsigned NUM_INT         = 8;
  localparam logic [7:0]  INT_SELFCHECK   = 8'h01;
  localparam logic [7:0]  INT_DETECT_KEEP = 8'h07;
  localparam logic [7:0]  INTEN_RESET     = 8'h01;
  localparam logic [15:0] WDT_RESET       = 16'hFFFF;

  typedef enum logic [3:0] {
    MODE_DEFAULT = 4'b0001,
    MODE_METER   = 4'b0010,
    MODE_SLEEP   = 4'b0100,
    MODE_DETECT  = 4'b1000
  } scdc_mode_type;

  typedef struct packed {
    logic xtalEn;
    logic rcFastEn;
    logic rcSlowEn;
    logic bandgapEn;
    logic biasEn;
    logic currAdcEn;
    logic voltAdcEn;
    logic meterEn;
    logic meterVerifyOnly;
    logic clkFromRc;
    logic meterClkFixed;
    logic uartIdle;
  } scdc_power_type;
endpackage

//--- verilog/scdc_sleep_ctrl.sv
// Power-mode sequencer with sleep entry, receive-pin wake and timed current detection.
module scdc_sleep_ctrl #(
  parameter int unsigned WAKE_CYC   = scdc_pkg::WAKE_HALF_CYC,
  parameter int unsigned SETTLE_CYC = scdc_pkg::RC_SETTLE_CYC,
  parameter int unsigned DETECT_CYC = scdc_pkg::DETECT_MAX_CYC
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // AHB-Lite slave.
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Pins and neighbouring logic.
  input  wire logic                  rxPin,
  input  wire logic                  uartTx,
  input  wire logic [7:0]            intSrc,
  input  wire logic                  detectDone,
  input  wire logic                  resetEvent,
  output logic                       txPin,
  output logic                       intPin,
  output scdc_pkg::scdc_power_type   power,
  output logic                       wdtReset
);
  import scdc_pkg::*;

  function automatic logic reached(input logic [TMR_W-1:0] cnt, input int unsigned lim);
    reached = (cnt >= TMR_W'(lim));
  endfunction

  function automatic logic [TMR_W-1:0] bump(input logic [TMR_W-1:0] cnt);
    bump = (cnt == {TMR_W{1'b1}}) ? cnt : cnt + 1'b1;
  endfunction

  // Receive pin synchroniser.
  logic rxMeta;
  logic rxSync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
    end
  end

  // Bus address phase capture.
  logic        wrPend;
  logic        next_wrPend;
  logic [11:0] wrAddr;
  logic [11:0] next_wrAddr;
  logic [31:0] next_hrdata;
  logic        busTake;

  // Registers and mode state.
  scdc_mode_type  mode;
  scdc_mode_type  next_mode;
  logic           meterRun;
  logic           next_meterRun;
  logic [7:0]     intEn;
  logic [7:0]     next_intEn;
  logic [15:0]    wdtInterval;
  logic [15:0]    next_wdtInterval;
  logic [WDT_W-1:0] wdtCnt;
  logic [WDT_W-1:0] next_wdtCnt;
  logic [TMR_W-1:0] lowCnt;
  logic [TMR_W-1:0] next_lowCnt;
  logic [TMR_W-1:0] highCnt;
  logic [TMR_W-1:0] next_highCnt;
  logic           lowOk;
  logic           next_lowOk;
  logic [TMR_W-1:0] detCnt;
  logic [TMR_W-1:0] next_detCnt;
  logic           rcStable;
  logic           next_rcStable;
  logic           next_txPin;
  logic           next_intPin;
  logic           next_wdtReset;
  scdc_power_type next_power;

  logic        wrCtrl;
  logic        wrInten;
  logic        wrWdt;
  logic        wrSoft;
  logic        anyReset;
  logic [7:0]  intMask;

  assign busTake = hsel && hready && htrans[1];

  always_comb begin
    next_wrPend = busTake && hwrite;
    next_wrAddr = busTake ? haddr[11:0] : wrAddr;
    next_hrdata = 32'h0000_0000;
    if (busTake && !hwrite) begin
      unique case (haddr[11:0])
        ADDR_SYSTEM_CONTROL_WORD: next_hrdata = {30'h0, meterRun, 1'b0};
        ADDR_INTEN:   next_hrdata = {24'h0, intEn};
        ADDR_STATUS:  next_hrdata = {27'h0, rcStable, mode};
        ADDR_WDT:     next_hrdata = {16'h0, wdtInterval};
        default:      next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign wrCtrl  = wrPend && (wrAddr == ADDR_SYSTEM_CONTROL_WORD);
  assign wrInten = wrPend && (wrAddr == ADDR_INTEN);
  assign wrWdt   = wrPend && (wrAddr == ADDR_WDT);
  assign wrSoft  = wrPend && (wrAddr == ADDR_SOFTRST) && hwdata[0];
  // Software reset, external reset events and watchdog overflow act alike.
  assign anyReset = wrSoft || resetEvent || wdtReset;

  // Mode sequencing, wake detection and detection timing.
  always_comb begin
    next_mode        = mode;
    next_meterRun    = meterRun;
    next_intEn       = intEn;
    next_wdtInterval = wdtInterval;
    next_lowCnt      = '0;
    next_highCnt     = '0;
    next_lowOk       = 1'b0;
    next_detCnt      = '0;
    next_rcStable    = 1'b0;
    if (wrInten) begin
      next_intEn = hwdata[7:0] | INT_SELFCHECK;
    end
    if (wrWdt) begin
      next_wdtInterval = hwdata[15:0];
    end
    unique case (mode)
      MODE_DEFAULT, MODE_METER: begin
        if (wrCtrl) begin
          next_meterRun = hwdata[BIT_METER];
          next_mode = hwdata[BIT_METER] ? MODE_METER : MODE_DEFAULT;
          if (hwdata[BIT_SLEEP]) begin
            next_mode = MODE_SLEEP;
          end
        end
      end
      MODE_SLEEP: begin
        // A high period only counts once a full low period has been seen.
        if (!rxSync) begin
          next_lowCnt = bump(lowCnt);
          next_lowOk  = reached(next_lowCnt, WAKE_CYC);
        end else if (lowOk) begin
          next_lowOk   = 1'b1;
          next_highCnt = bump(highCnt);
          if (reached(next_highCnt, WAKE_CYC)) begin
            next_mode  = MODE_DETECT;
            next_lowOk = 1'b0;
          end
        end
      end
      MODE_DETECT: begin
        next_detCnt   = bump(detCnt);
        next_rcStable = rcStable || reached(next_detCnt, SETTLE_CYC);
        if ((rcStable && detectDone) || reached(next_detCnt, DETECT_CYC)) begin
          next_mode = MODE_SLEEP;
        end
      end
      default: next_mode = MODE_DEFAULT;
    endcase
    if (anyReset) begin
      next_mode        = MODE_DEFAULT;
      next_meterRun    = 1'b0;
      next_intEn       = INTEN_RESET;
      next_wdtInterval = WDT_RESET;
      next_rcStable    = 1'b0;
      next_detCnt      = '0;
    end
  end

  // Watchdog keeps counting in every mode; writing its register reloads it.
  always_comb begin
    next_wdtReset = 1'b0;
    next_wdtCnt   = wdtCnt + 1'b1;
    if (wrWdt || anyReset) begin
      next_wdtCnt = '0;
    end else if (wdtCnt >= WDT_W'({10'h0, wdtInterval} * WDT_TICK_CYC)) begin
      next_wdtReset = 1'b1;
      next_wdtCnt   = '0;
    end
  end

  // Power, clock and pin outputs, registered from the next mode.
  always_comb begin
    next_power = '0;
    next_power.rcSlowEn = 1'b1;
    intMask = intEn | INT_SELFCHECK;
    unique case (next_mode)
      MODE_DEFAULT, MODE_METER: begin
        next_power.xtalEn    = 1'b1;
        next_power.bandgapEn = 1'b1;
        next_power.biasEn    = 1'b1;
        next_power.currAdcEn = meterRun || next_meterRun;
        next_power.voltAdcEn = meterRun || next_meterRun;
        next_power.meterEn   = 1'b1;
        next_power.meterVerifyOnly = (next_mode == MODE_DEFAULT);
      end
      MODE_SLEEP: begin
        // Every enable other than the slow oscillator stays low here.
        next_power.uartIdle = 1'b1;
      end
      MODE_DETECT: begin
        next_power.rcFastEn        = 1'b1;
        next_power.clkFromRc       = 1'b1;
        next_power.meterClkFixed   = 1'b1;
        next_power.bandgapEn       = 1'b1;
        next_power.biasEn          = 1'b1;
        next_power.currAdcEn       = next_rcStable;
        next_power.meterEn         = next_rcStable;
        next_power.meterVerifyOnly = 1'b1;
        intMask = intEn & INT_DETECT_KEEP | INT_SELFCHECK;
      end
      default: next_power = '0;
    endcase
    next_txPin  = (next_mode == MODE_SLEEP) ? 1'b1 : uartTx;
    // Interrupt logic stays live in every mode, sleep included.
    next_intPin = |(intSrc & intMask);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend      <= 1'b0;
      wrAddr      <= 12'h000;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
      mode        <= MODE_DEFAULT;
      meterRun    <= 1'b0;
      intEn       <= INTEN_RESET;
      wdtInterval <= WDT_RESET;
      wdtCnt      <= '0;
      wdtReset    <= 1'b0;
      lowCnt      <= '0;
      highCnt     <= '0;
      lowOk       <= 1'b0;
      detCnt      <= '0;
      rcStable    <= 1'b0;
      txPin       <= 1'b1;
      intPin      <= 1'b0;
      power       <= '0;
    end else begin
      wrPend      <= next_wrPend;
      wrAddr      <= next_wrAddr;
      hrdata      <= next_hrdata;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      mode        <= next_mode;
      meterRun    <= next_meterRun;
      intEn       <= next_intEn;
      wdtInterval <= next_wdtInterval;
      wdtCnt      <= next_wdtCnt;
      wdtReset    <= next_wdtReset;
      lowCnt      <= next_lowCnt;
      highCnt     <= next_highCnt;
      lowOk       <= next_lowOk;
      detCnt      <= next_detCnt;
      rcStable    <= next_rcStable;
      txPin       <= next_txPin;
      intPin      <= next_intPin;
      power       <= next_power;
    end
  end
endmodule
